// >>> design/codec_serial_port.sv
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "codec_port_defines.svh"

module codec_serial_port
  import codec_port_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_sclk,
  input  wire logic        i_din,
  input  wire logic        i_hw_secondary_request,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_ack,
  output logic      [31:0] o_wb_dat,
  output logic             o_frame_sync,
  output logic             o_dout,
  output logic             o_dout_oe,
  output logic      [15:0] o_dac_word,
  output logic             o_dac_valid,
  output logic             o_adc_aux_sel,
  output logic             o_mon_aux_sel,
  output logic      [1:0]  o_input_gain
);

  // ----------------------------------------------------------------
  // Synchronised link inputs
  // ----------------------------------------------------------------
  logic [2:0] lvl;
  logic       sclk_lvl, din_lvl, fc_lvl;

  codec_link_sync u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_hw_secondary_request, i_din, i_sclk}),
    .o_level (lvl)
  );

  assign sclk_lvl = lvl[0];
  assign din_lvl  = lvl[1];
  assign fc_lvl   = lvl[2];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic              sclk_prev_q;
  logic              sclk_rise, sclk_fall;
  logic [7:0]        cnt_q, cnt_d;
  frame_kind_t       fr_q, fr_d;
  logic              sec_q, sec_d;
  word_t             tx_q, tx_d;
  word_t             rx_q, rx_d;
  logic [3:0][7:0]   ctl_q, ctl_d;
  word_t             dac_q, dac_d;
  logic              vld_q, vld_d;
  logic              fs_q, fs_d;
  logic              dout_q, dout_d;
  logic              oe_q, oe_d;
  logic              mode16;
  logic [4:0]        early_addr, full_addr;
  ctl_byte_t         rd_byte;

  logic              en_q, en_d;
  word_t             adc_q, adc_d;
  logic              ack_q, ack_d;
  logic [31:0]       wdat_q, wdat_d;
  logic [31:0]       rdat;

  assign sclk_rise = sclk_lvl & ~sclk_prev_q;
  assign sclk_fall = ~sclk_lvl & sclk_prev_q;
  assign mode16    = ctl_q[`CTL1_IDX][`CTL1_WORD16];

  // Address known after the first byte of a secondary word arrives
  assign early_addr = rx_q[`SEC_ADDR_EHI:0];
  assign full_addr  = rx_q[`SEC_ADDR_HI:`SEC_ADDR_LO];

  // ----------------------------------------------------------------
  // Read-back byte for a secondary read
  // ----------------------------------------------------------------
  // Pseudo-register zero and unused addresses read as zero
  always_comb begin
    rd_byte = `ZERO_BYTE;
    if (rx_q[`SEC_RW_EARLY] && early_addr != `REG_NULL &&
        early_addr <= `REG_MAX) begin
      rd_byte = ctl_q[2'(early_addr - `REG_ONE)];
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer and shifters
  // ----------------------------------------------------------------
  // While enabled, everything moves on bit clock edges found in the system clock
  always_comb begin
    cnt_d  = cnt_q;
    fr_d   = fr_q;
    sec_d  = sec_q;
    tx_d   = tx_q;
    rx_d   = rx_q;
    ctl_d  = ctl_q;
    dac_d  = dac_q;
    vld_d  = 1'b0;
    fs_d   = fs_q;
    dout_d = dout_q;
    oe_d   = oe_q;
    if (!en_q) begin
      // Parked so the next enabled rise opens a primary frame
      cnt_d  = `CNT_LAST;
      fr_d   = FR_NONE;
      sec_d  = 1'b0;
      fs_d   = 1'b1;
      oe_d   = 1'b0;
      dout_d = 1'b0;
    end else begin
      if (sclk_fall && fr_q != FR_NONE) begin
        rx_d = {rx_q[14:0], din_lvl};
      end
      if (sclk_rise) begin
        cnt_d = cnt_q + `CNT_STEP;
        tx_d  = {tx_q[14:0], 1'b0};
        case (cnt_d)
          `PRI_FIRST: begin
            fr_d = FR_PRIMARY;
            tx_d = adc_q;
          end
          `PRI_END: begin
            fr_d  = FR_NONE;
            vld_d = 1'b1;
            // LSB is a control bit only in 15-bit mode
            dac_d = mode16 ? rx_q : {rx_q[15:1], 1'b0};
            sec_d = fc_lvl | (~mode16 & rx_q[0]);
          end
          `SEC_FIRST: begin
            if (sec_q) begin
              fr_d = FR_SECONDARY;
              tx_d = `WORD_RESET;
            end
          end
          `SEC_DATA: begin
            if (fr_q == FR_SECONDARY) begin
              tx_d = {rd_byte, `ZERO_BYTE};
            end
          end
          `SEC_END: begin
            if (fr_q == FR_SECONDARY) begin
              fr_d  = FR_NONE;
              sec_d = 1'b0;
              if (!rx_q[`SEC_RW_BIT] && full_addr != `REG_NULL &&
                  full_addr <= `REG_MAX) begin
                ctl_d[2'(full_addr - `REG_ONE)] = rx_q[7:0];
              end
            end
          end
          default: ;
        endcase
        fs_d   = (fr_d == FR_NONE);
        oe_d   = ~fs_d;
        dout_d = tx_d[15];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_prev_q <= 1'b0;
      cnt_q       <= `CNT_LAST;
      fr_q        <= FR_NONE;
      sec_q       <= 1'b0;
      tx_q        <= `WORD_RESET;
      rx_q        <= `WORD_RESET;
      ctl_q       <= {4{`CTL_RESET}};
      dac_q       <= `WORD_RESET;
      vld_q       <= 1'b0;
      fs_q        <= 1'b1;
      dout_q      <= 1'b0;
      oe_q        <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_lvl;
      cnt_q       <= cnt_d;
      fr_q        <= fr_d;
      sec_q       <= sec_d;
      tx_q        <= tx_d;
      rx_q        <= rx_d;
      ctl_q       <= ctl_d;
      dac_q       <= dac_d;
      vld_q       <= vld_d;
      fs_q        <= fs_d;
      dout_q      <= dout_d;
      oe_q        <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Read mux; unmapped offsets read as zero
  always_comb begin
    case (i_wb_adr)
      `WB_CTRL: rdat = {29'h0, mode16, sec_q, en_q};
      `WB_ADC:  rdat = {16'h0, adc_q};
      `WB_DAC:  rdat = {16'h0, dac_q};
      `WB_STAT: rdat = ctl_q;
      default:  rdat = `WB_ZERO;
    endcase
  end

  // One wait state; ack drops the cycle after it is given
  always_comb begin
    ack_d  = i_wb_cyc & i_wb_stb & ~ack_q;
    wdat_d = ack_d ? rdat : `WB_ZERO;
    en_d   = en_q;
    adc_d  = adc_q;
    if (ack_d && i_wb_we) begin
      case (i_wb_adr)
        `WB_CTRL: begin
          if (i_wb_sel[0]) begin
            en_d = i_wb_dat[0];
          end
        end
        `WB_ADC: begin
          if (i_wb_sel[0]) begin
            adc_d[7:0] = i_wb_dat[7:0];
          end
          if (i_wb_sel[1]) begin
            adc_d[15:8] = i_wb_dat[15:8];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q  <= 1'b0;
      wdat_q <= `WB_ZERO;
      en_q   <= `WB_EN_RESET;
      adc_q  <= `WORD_RESET;
    end else begin
      ack_q  <= ack_d;
      wdat_q <= wdat_d;
      en_q   <= en_d;
      adc_q  <= adc_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_wb_ack      = ack_q;
  assign o_wb_dat      = wdat_q;
  assign o_frame_sync  = fs_q;
  assign o_dout        = dout_q;
  assign o_dout_oe     = oe_q;
  assign o_dac_word    = dac_q;
  assign o_dac_valid   = vld_q;
  assign o_adc_aux_sel = ctl_q[`CTL1_IDX][`CTL1_ADC_AUX];
  assign o_mon_aux_sel = ctl_q[`CTL1_IDX][`CTL1_MON_AUX];
  assign o_input_gain  =
    ctl_q[`CTL4_IDX][`CTL4_GAIN_HI:`CTL4_GAIN_LO];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  logic step;
  assign step = en_q & sclk_rise;

  sequence s_pri_close;
    step && cnt_q == `PRI_LASTBIT;
  endsequence

  sequence s_sec_close;
    step && cnt_q == `SEC_LASTBIT && fr_q == FR_SECONDARY;
  endsequence

  property p_pri_open;
    step && cnt_q == `CNT_LAST |=> !fs_q && fr_q == FR_PRIMARY;
  endproperty
  a_pri_open: assert property (p_pri_open)
    else $error("primary frame did not open");

  property p_pri_close;
    s_pri_close |=> fs_q && vld_q;
  endproperty
  a_pri_close: assert property (p_pri_close)
    else $error("primary frame did not close after 16 bits");

  property p_no_request;
    step && cnt_q == `SEC_PREV && !sec_q |=> fs_q;
  endproperty
  a_no_request: assert property (p_no_request)
    else $error("secondary frame without request");

  property p_sec_open;
    step && cnt_q == `SEC_PREV && sec_q |=> !fs_q ##1 oe_q;
  endproperty
  a_sec_open: assert property (p_sec_open)
    else $error("secondary frame not at bit 128");

  property p_fs_window;
    !fs_q |-> cnt_q <= `PRI_LASTBIT ||
      (cnt_q >= `SEC_FIRST && cnt_q <= `SEC_LASTBIT);
  endproperty
  a_fs_window: assert property (p_fs_window)
    else $error("frame sync low outside a frame slot");

  property p_hw_req;
    s_pri_close and fc_lvl |=> sec_q;
  endproperty
  a_hw_req: assert property (p_hw_req)
    else $error("hardware request not taken at frame end");

  property p_lsb_req;
    s_pri_close and !mode16 && rx_q[0] |=> sec_q && !dac_q[0];
  endproperty
  a_lsb_req: assert property (p_lsb_req)
    else $error("LSB request not taken in 15-bit mode");

  property p_word16;
    s_pri_close and mode16 && !fc_lvl |=> !sec_q &&
      dac_q == $past(rx_q);
  endproperty
  a_word16: assert property (p_word16)
    else $error("16-bit mode word mishandled");

  property p_ctl_stable;
    !(step && cnt_q == `SEC_LASTBIT) |=> $stable(ctl_q);
  endproperty
  a_ctl_stable: assert property (p_ctl_stable)
    else $error("control changed outside secondary end");

  property p_null_op;
    s_sec_close and full_addr == `REG_NULL |=> $stable(ctl_q);
  endproperty
  a_null_op: assert property (p_null_op)
    else $error("null register operation changed a register");

  property p_write_one;
    s_sec_close and !rx_q[`SEC_RW_BIT] && full_addr == `REG_ONE
      |=> ctl_q[`CTL1_IDX] == $past(rx_q[7:0]);
  endproperty
  a_write_one: assert property (p_write_one)
    else $error("secondary write not stored");

  property p_low_zero;
    step && cnt_q == `SEC_HALF && fr_q == FR_SECONDARY &&
      !rx_q[`SEC_RW_EARLY] |=> tx_q == `WORD_RESET;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("low byte not zero without a read");

  property p_msb_first;
    step && cnt_q == `CNT_LAST |=> dout_q == $past(adc_q[15]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("sample word not MSB first");

endmodule

`default_nettype wire

// >>> design/codec_port_defines.svh
// Notes on behaviour
// - Every conversion period carries one sample-only primary frame
// - Secondary frame only after hardware or LSB request
// - Control 1 bit picks 15/16-bit; reset 15-bit
// - 15-bit mode: word LSB 1 requests secondary
// - 16-bit mode: all bits data, hardware request only
// - Frame sync low while 16 bits exchanged
// - Control registers change only in secondary frames
// - Register zero address is a null operation
// - Secondary write takes input; read shifts register out
// - Hardware request sampled at frame sync rise
// - Secondary frame sync falls 128 bit clocks in
// - Control 1 bits select ADC and monitor inputs
// - Control 4 field sets input amplifier gain
// - No read: low secondary output byte is zero
// - Words shift MSB first, two's complement samples
// - Frame every 256 bit clocks
`ifndef CODEC_PORT_DEFINES_SVH
`define CODEC_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// Frame timing, in bit clock positions
// ----------------------------------------------------------------
`define CNT_LAST     8'hFF
`define PRI_FIRST    8'h00
`define PRI_LASTBIT  8'h0F
`define PRI_END      8'h10
`define SEC_PREV     8'h7F
`define SEC_FIRST    8'h80
`define SEC_HALF     8'h87
`define SEC_DATA     8'h88
`define SEC_LASTBIT  8'h8F
`define SEC_END      8'h90
`define CNT_STEP     8'h01

// ----------------------------------------------------------------
// Secondary word layout
// ----------------------------------------------------------------
`define SEC_RW_BIT    13
`define SEC_ADDR_HI   12
`define SEC_ADDR_LO   8
`define SEC_RW_EARLY  5
`define SEC_ADDR_EHI  4
`define REG_NULL      5'h00
`define REG_MAX       5'h04
`define REG_ONE       5'h01
`define ZERO_BYTE     8'h00
`define CTL_RESET     8'h00
`define WORD_RESET    16'h0000

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL1_IDX       0
`define CTL4_IDX       3
`define CTL1_WORD16    0
`define CTL1_ADC_AUX   4
`define CTL1_MON_AUX   5
`define CTL4_GAIN_HI   1
`define CTL4_GAIN_LO   0

// ----------------------------------------------------------------
// Wishbone register map
// ----------------------------------------------------------------
`define WB_CTRL      4'h0
`define WB_ADC       4'h4
`define WB_DAC       4'h8
`define WB_STAT      4'hC
`define WB_EN_RESET  1'b1
`define WB_ZERO      32'h0000_0000

`endif

// >>> design/codec_port_pkg.sv
package codec_port_pkg;

  typedef logic [15:0] word_t;
  typedef logic [7:0]  ctl_byte_t;

  // Which kind of frame the port is in
  typedef enum logic [1:0] {
    FR_NONE,
    FR_PRIMARY,
    FR_SECONDARY
  } frame_kind_t;

endpackage

// >>> design/codec_link_sync.sv
`timescale 1ns/1ps
`default_nettype none

module codec_link_sync (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [2:0] i_async,
  output logic      [2:0] o_level
);

  logic [2:0] s1_q, s2_q, s3_q, lvl_q;
  logic [2:0] lvl_d;

  // ----------------------------------------------------------------
  // Level accepted only once stages two and three agree
  // ----------------------------------------------------------------
  // Stage one feeds stage two alone, so metastability stays contained
  always_comb begin
    lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q  <= 3'h0;
      s2_q  <= 3'h0;
      s3_q  <= 3'h0;
      lvl_q <= 3'h0;
    end else begin
      s1_q  <= i_async;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;

endmodule

`default_nettype wire

// >>> tb/codec_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// Host serial port facing the codec
// ------------------------------------------------
module codec_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_frame_sync,
  input  wire logic        i_dout,
  input  wire logic        i_dout_oe,
  input  wire logic [15:0] i_tx_pri,
  input  wire logic [15:0] i_tx_sec,
  output logic             o_sclk,
  output logic             o_din,
  output logic      [15:0] o_rx_word,
  output logic             o_rx_sec,
  output logic             o_rx_stb
);
  logic [2:0]  div_q;
  logic [8:0]  rises_q;
  logic [15:0] tx_q;
  logic        fs_q;
  logic        sec_slot;

  // Secondary opens half a period after its primary; a primary opens a
  // full period after the last one, so only the middle window is secondary
  assign sec_slot = rises_q > 9'h040 && rises_q < 9'h0C0;

  // Bit clock runs free at 16 system clocks a period; the device counts
  // its frames from it.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q     <= 3'h0;
      o_sclk    <= 1'b0;
      fs_q      <= 1'b1;
      rises_q   <= 9'h000;
      tx_q      <= 16'h0000;
      o_din     <= 1'b0;
      o_rx_word <= 16'h0000;
      o_rx_sec  <= 1'b0;
      o_rx_stb  <= 1'b0;
    end else begin
      div_q    <= div_q + 3'h1;
      fs_q     <= i_frame_sync;
      o_rx_stb <= !fs_q && i_frame_sync;
      if (div_q == 3'h7) begin
        o_sclk <= ~o_sclk;
      end
      if (div_q == 3'h7 && !o_sclk) begin
        rises_q <= rises_q + 9'h001;
        if (!i_frame_sync) begin
          tx_q  <= {tx_q[14:0], 1'b0};
          o_din <= tx_q[14];
        end
      end
      // Undriven output poisons the word so a wrong enable shows
      if (div_q == 3'h7 && o_sclk && !i_frame_sync) begin
        o_rx_word <= {o_rx_word[14:0],
                      i_dout_oe ? i_dout : 1'bx};
      end
      if (fs_q && !i_frame_sync) begin
        o_rx_sec <= sec_slot;
        tx_q     <= sec_slot ? i_tx_sec : i_tx_pri;
        o_din    <= sec_slot ? i_tx_sec[15] : i_tx_pri[15];
        if (!sec_slot) begin
          rises_q <= 9'h000;
        end
      end
      // Released line shows the inverse of its last bit
      if (!fs_q && i_frame_sync) begin
        o_din <= ~o_din;
      end
    end
  end
endmodule

`default_nettype wire

// >>> tb/codec_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module codec_serial_port_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hw_req = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [15:0] tx_pri = 16'h0000;
  logic [15:0] tx_sec = 16'h0000;
  logic        sclk, din, ack, fs, dout, oe, dac_valid;
  logic        adc_aux, mon_aux, rx_sec, rx_stb;
  logic [1:0]  gain;
  logic [15:0] dac_word, rx_word;
  logic [31:0] rdat, r;
  logic [7:0]  ctl [1:4];
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc_n = 0;
  int          last_fall = 0;
  int          fall_gap = 0;
  int          low_run = 0;
  int          low_len = 0;
  logic        fs_d = 1'b1;
  logic        had_sec = 1'b1;

  always #5 clk = ~clk;

  codec_serial_port codec_serial_port_i (
    .i_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_din(din),
    .i_hw_secondary_request(hw_req), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .o_frame_sync(fs), .o_dout(dout),
    .o_dout_oe(oe), .o_dac_word(dac_word), .o_dac_valid(dac_valid),
    .o_adc_aux_sel(adc_aux), .o_mon_aux_sel(mon_aux),
    .o_input_gain(gain));

  codec_host_model codec_host_model_i (
    .i_clk(clk), .i_rst_b(rst_b), .i_frame_sync(fs), .i_dout(dout),
    .i_dout_oe(oe), .i_tx_pri(tx_pri), .i_tx_sec(tx_sec), .o_sclk(sclk),
    .o_din(din), .o_rx_word(rx_word), .o_rx_sec(rx_sec),
    .o_rx_stb(rx_stb));

  // ------------------------------------------------
  // Frame sync timing in system clocks
  // ------------------------------------------------
  // Both edges pass one synchroniser, so spacing is exact
  always @(posedge clk) begin
    cyc_n   <= cyc_n + 1;
    fs_d    <= fs;
    low_run <= fs ? 0 : low_run + 1;
    if (fs_d && !fs) begin
      fall_gap  <= cyc_n - last_fall;
      last_fall <= cyc_n;
    end
    if (!fs_d && fs) begin
      low_len <= low_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Classic cycle; held until ack is seen at an edge
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
    @(posedge clk);
  endtask

  task automatic wait_stb();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rx_stb !== 1'b1 && n < 5000);
    if (rx_stb !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask

  // One conversion period: primary, then a secondary if requested
  task automatic frame(input logic [15:0] pri, input logic [15:0] sec,
                       input logic hw);
    logic [15:0] adc, dac;
    logic [7:0]  rd;
    logic [4:0]  ra;
    logic        req, got, wr;
    int          n;
    adc = 16'($urandom);
    ra  = sec[12:8];
    wr  = ra >= 5'h01 && ra <= 5'h04;
    req = hw | (~ctl[1][0] & pri[0]);
    dac = ctl[1][0] ? pri : {pri[15:1], 1'b0};
    rd  = (sec[13] && wr) ? ctl[ra[2:0]] : 8'h00;
    wb(1'b1, 4'h4, {16'h0000, adc}, r);
    tx_pri <= pri;
    tx_sec <= sec;
    hw_req <= hw;
    wait_stb();
    hw_req <= 1'b0;
    chk(rx_word, adc);
    chk(low_len, 256);
    if (!had_sec) chk(fall_gap, 4096);
    wb(1'b0, 4'h8, 32'h0000_0000, r);
    chk(r, {16'h0000, dac});
    chk(dac_word, dac);
    got = 1'b0;
    for (n = 0; n < 2560 && !got; n++) begin
      @(posedge clk);
      got = rx_stb;
    end
    chk(got, req);
    had_sec = got;
    if (got) begin
      chk(rx_word, {8'h00, rd});
      chk(fall_gap, 2048);
      chk(low_len, 256);
      if (!sec[13] && wr) ctl[ra[2:0]] = sec[7:0];
    end
    wb(1'b0, 4'hC, 32'h0000_0000, r);
    chk(r, {ctl[4], ctl[3], ctl[2], ctl[1]});
    chk({adc_aux, mon_aux, gain},
        {ctl[1][4], ctl[1][5], ctl[4][1:0]});
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    void'($urandom(32'hC6AE));
    for (int i = 1; i <= 4; i++) ctl[i] = 8'h00;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({fs, oe, dac_valid, adc_aux, mon_aux, gain}, 7'h40);
    wb(1'b0, 4'h0, 32'h0000_0000, r);
    chk(r & 32'hFFFF_FFFD, 32'h0000_0001);
    wb(1'b1, 4'h8, 32'h0000_FFFF, r);
    wb(1'b0, 4'h8, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    wb(1'b0, 4'h2, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    wait_stb();
    repeat (2) frame(16'($urandom) & 16'hFFFE, 16'h0131, 1'b0);
    frame(16'($urandom) | 16'h0001, 16'h0131, 1'b0);
    wb(1'b0, 4'h0, 32'h0000_0000, r);
    chk(r & 32'hFFFF_FFFD, 32'h0000_0005);
    frame(16'($urandom) | 16'h0001, 16'h0000, 1'b0);
    frame(16'($urandom), 16'h2100, 1'b1);
    frame(16'($urandom), 16'h0403, 1'b1);
    frame(16'($urandom), 16'h00FF, 1'b1);
    frame(16'($urandom), 16'h2000, 1'b1);
    for (int i = 1; i <= 4; i++) begin
      frame(16'($urandom), {3'h0, 5'(i), 8'($urandom)}, 1'b1);
      frame(16'($urandom), {3'h1, 5'(i), 8'h00}, 1'b1);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
